/* psq_map.svh */
`ifndef PSQ_MAP_SVH
`define PSQ_MAP_SVH
// Function
// - eleven-bit program counter addresses a 2048 by 16 program memory.
// - jump, call, interrupt and reset load the counter instead of incrementing.
// - vectors 000, 004, 008, 00C, 014 and 020 hex for reset and interrupts.
// - pending interrupts served in order divider 0, timer 0, port RC, divider 1, timer 1.
// - eight-entry last-in first-out return stack, eleven bits per entry.
// - calls and taken interrupts push the return address automatically.
// - return instruction pops the top entry into the program counter.
// - ninth push drops the oldest entry; depth never exceeds eight.
// - 000-5FF hold code only; 600-7FF hold code and table data.
// - table elements are four bits; up to 2048 elements addressable.
// - high and low table pointers loaded from data memory by own moves.
// - table read fetches element by pointers and work nibble into data memory.
`define PSQ_PC_W 11
`define PSQ_NIB_W 4
`define PSQ_RAM_AW 7
`define PSQ_STACK_DEPTH 8
`define PSQ_INT_N 5
`define PSQ_VEC_RESET 11'h000
`define PSQ_VEC_DIV0 11'h004
`define PSQ_VEC_TMR0 11'h008
`define PSQ_VEC_PORTRC 11'h00c
`define PSQ_VEC_DIV1 11'h014
`define PSQ_VEC_TMR1 11'h020
`define PSQ_TABLE_BASE 11'h600
`define PSQ_PC_ONE 11'h001
`define PSQ_SEL_W 2
`define PSQ_WORD_W 16
`define PSQ_INT_DIV0 0
`define PSQ_INT_TMR0 1
`define PSQ_INT_PORTRC 2
`define PSQ_INT_DIV1 3
`define PSQ_INT_TMR1 4
`endif

/* psq_pkg.sv */
package psq_pkg;
   typedef enum logic [1:0] {
      psq_run,
      psq_table_fetch,
      psq_table_write
   } psq_state_type;
endpackage : psq_pkg

/* psq_stack.sv */
`include "psq_map.svh"
module psq_stack
   import psq_pkg::*;
#(
   parameter int DEPTH = `PSQ_STACK_DEPTH,
   parameter int WIDTH = `PSQ_PC_W
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] entry [DEPTH];
   logic [PW-1:0] top;
   logic [PW-1:0] next_top;
   logic [LW-1:0] next_level;

   // circular storage: a push past full overwrites the oldest slot
   always_comb begin
      next_top = top;
      next_level = level;
      if (push) begin
         next_top = top + PW'(1);
         if (level != LW'(DEPTH)) begin
            next_level = level + LW'(1);
         end
      end else if (pop && level != '0) begin
         next_top = top - PW'(1);
         next_level = level - LW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         top <= '0;
         level <= '0;
      end else begin
         top <= next_top;
         level <= next_level;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         entry[next_top] <= push_data;
      end
   end

   // pop on empty returns stale data, as the real stack would
   assign top_data = entry[top];
endmodule : psq_stack

/* psq_sequencer.sv */
`include "psq_map.svh"
module psq_sequencer
   import psq_pkg::*;
#(
   parameter int PC_W = `PSQ_PC_W,
   parameter int DEPTH = `PSQ_STACK_DEPTH
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic step,
   input wire logic jump_instruction,
   input wire logic call_instruction,
   input wire logic return_instruction,
   input wire logic [PC_W-1:0] operand_addr,
   input wire logic int_take,
   input wire logic [`PSQ_INT_N-1:0] int_pending,
   input wire logic load_table_high,
   input wire logic load_table_low,
   input wire logic [`PSQ_NIB_W-1:0] ram_read_data,
   input wire logic table_read_instruction,
   input wire logic [`PSQ_NIB_W-1:0] work_nibble_reg,
   input wire logic [`PSQ_RAM_AW-1:0] ram_dest_addr,
   input wire logic [`PSQ_WORD_W-1:0] rom_data,
   output logic [PC_W-1:0] program_counter,
   output logic [PC_W-1:0] rom_addr,
   output logic [`PSQ_INT_N-1:0] int_ack,
   output logic busy,
   output logic ram_write,
   output logic [`PSQ_RAM_AW-1:0] ram_write_addr,
   output logic [`PSQ_NIB_W-1:0] ram_write_data,
   output logic [$clog2(DEPTH+1)-1:0] stack_level
);
   localparam int NW = `PSQ_NIB_W;
   localparam int AW = `PSQ_RAM_AW;
   localparam int LW = $clog2(DEPTH+1);

   psq_state_type state;
   psq_state_type next_state;
   logic [PC_W-1:0] next_program_counter;
   logic [PC_W-1:0] next_rom_addr;
   logic [`PSQ_INT_N-1:0] next_int_ack;
   logic next_busy;
   logic next_ram_write;
   logic [AW-1:0] next_ram_write_addr;
   logic [NW-1:0] next_ram_write_data;
   logic [NW-1:0] table_pointer_high;
   logic [NW-1:0] table_pointer_low;
   logic [NW-1:0] next_table_pointer_high;
   logic [NW-1:0] next_table_pointer_low;
   logic [`PSQ_SEL_W-1:0] nibble_sel;
   logic [`PSQ_SEL_W-1:0] next_nibble_sel;
   logic [AW-1:0] dest;
   logic [AW-1:0] next_dest;

   logic push;
   logic pop;
   logic [PC_W-1:0] push_data;
   logic [PC_W-1:0] stack_top;
   logic [LW-1:0] level;
   logic [PC_W-1:0] int_vector;
   logic [`PSQ_INT_N-1:0] int_grant;
   logic [PC_W-1:0] element_addr;
   logic [PC_W-1:0] pc_plus_one;

   psq_stack #(
      .DEPTH(DEPTH),
      .WIDTH(PC_W)
   ) u_stack (
      .clk_sys(clk_sys),
      .reset(reset),
      .push(push),
      .pop(pop),
      .push_data(push_data),
      .top_data(stack_top),
      .level(level)
   );

   // fixed priority: lowest index wins
   always_comb begin
      int_grant = '0;
      int_vector = `PSQ_VEC_DIV0;
      if (int_pending[`PSQ_INT_DIV0]) begin
         int_grant[`PSQ_INT_DIV0] = 1'b1;
         int_vector = `PSQ_VEC_DIV0;
      end else if (int_pending[`PSQ_INT_TMR0]) begin
         int_grant[`PSQ_INT_TMR0] = 1'b1;
         int_vector = `PSQ_VEC_TMR0;
      end else if (int_pending[`PSQ_INT_PORTRC]) begin
         int_grant[`PSQ_INT_PORTRC] = 1'b1;
         int_vector = `PSQ_VEC_PORTRC;
      end else if (int_pending[`PSQ_INT_DIV1]) begin
         int_grant[`PSQ_INT_DIV1] = 1'b1;
         int_vector = `PSQ_VEC_DIV1;
      end else if (int_pending[`PSQ_INT_TMR1]) begin
         int_grant[`PSQ_INT_TMR1] = 1'b1;
         int_vector = `PSQ_VEC_TMR1;
      end
   end

   // high, low, work nibble; bit 11 of the twelve falls away
   assign element_addr = PC_W'({table_pointer_high, table_pointer_low, work_nibble_reg});
   assign pc_plus_one = program_counter + `PSQ_PC_ONE;

   always_comb begin
      next_state = state;
      next_program_counter = program_counter;
      next_int_ack = '0;
      next_ram_write = 1'b0;
      next_ram_write_addr = ram_write_addr;
      next_ram_write_data = ram_write_data;
      next_table_pointer_high = table_pointer_high;
      next_table_pointer_low = table_pointer_low;
      next_nibble_sel = nibble_sel;
      next_dest = dest;
      next_rom_addr = program_counter;
      push = 1'b0;
      pop = 1'b0;
      push_data = pc_plus_one;
      unique case (state)
         psq_run: begin
            if (load_table_high) begin
               next_table_pointer_high = ram_read_data;
            end
            if (load_table_low) begin
               next_table_pointer_low = ram_read_data;
            end
            // interrupt preempts the instruction; resume at the current address
            if (int_take && int_pending != '0) begin
               push = 1'b1;
               push_data = program_counter;
               next_program_counter = int_vector;
               next_int_ack = int_grant;
            end else if (call_instruction) begin
               push = 1'b1;
               next_program_counter = operand_addr;
            end else if (jump_instruction) begin
               next_program_counter = operand_addr;
            end else if (return_instruction) begin
               pop = 1'b1;
               next_program_counter = stack_top;
            end else if (table_read_instruction) begin
               // element lives in the upper quarter, four per word
               next_rom_addr = `PSQ_TABLE_BASE + (element_addr >> `PSQ_SEL_W);
               next_nibble_sel = element_addr[`PSQ_SEL_W-1:0];
               next_dest = ram_dest_addr;
               next_state = psq_table_fetch;
            end else if (step) begin
               next_program_counter = pc_plus_one;
            end
            if (next_state == psq_run) begin
               next_rom_addr = next_program_counter;
            end
         end
         psq_table_fetch: begin
            // rom answers one cycle after the address
            next_rom_addr = rom_addr;
            next_state = psq_table_write;
         end
         psq_table_write: begin
            next_ram_write = 1'b1;
            next_ram_write_addr = dest;
            next_ram_write_data = rom_data[nibble_sel*NW +: NW];
            next_program_counter = pc_plus_one;
            next_rom_addr = pc_plus_one;
            next_state = psq_run;
         end
      endcase
      next_busy = (next_state != psq_run);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= psq_run;
         program_counter <= `PSQ_VEC_RESET;
         rom_addr <= `PSQ_VEC_RESET;
         int_ack <= '0;
         busy <= 1'b0;
         ram_write <= 1'b0;
         ram_write_addr <= '0;
         ram_write_data <= '0;
         table_pointer_high <= '0;
         table_pointer_low <= '0;
         nibble_sel <= '0;
         dest <= '0;
         stack_level <= '0;
      end else begin
         state <= next_state;
         program_counter <= next_program_counter;
         rom_addr <= next_rom_addr;
         int_ack <= next_int_ack;
         busy <= next_busy;
         ram_write <= next_ram_write;
         ram_write_addr <= next_ram_write_addr;
         ram_write_data <= next_ram_write_data;
         table_pointer_high <= next_table_pointer_high;
         table_pointer_low <= next_table_pointer_low;
         nibble_sel <= next_nibble_sel;
         dest <= next_dest;
         stack_level <= level;
      end
   end
endmodule : psq_sequencer

/* psq_rom_model.sv */
module psq_rom_model (
   input wire logic clk_sys,
   input wire logic [10:0] rom_addr,
   output logic [15:0] rom_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // synchronous word, one cycle after the address
   always_ff @(posedge clk_sys) begin
      rom_data <= {~rom_addr[4:0], rom_addr};
   end
endmodule : psq_rom_model

/* psq_props.sv */
module psq_props (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic step,
   input wire logic jump_instruction,
   input wire logic call_instruction,
   input wire logic return_instruction,
   input wire logic [10:0] operand_addr,
   input wire logic int_take,
   input wire logic [4:0] int_pending,
   input wire logic table_read_instruction,
   input wire logic [6:0] ram_dest_addr,
   input wire logic [10:0] program_counter,
   input wire logic [4:0] int_ack,
   input wire logic busy,
   input wire logic ram_write,
   input wire logic [6:0] ram_write_addr,
   input wire logic [3:0] stack_level
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic quiet;
   assign quiet = !busy && !(int_take && |int_pending);
   sequence s_tr;
      quiet && table_read_instruction && !call_instruction && !jump_instruction && !return_instruction;
   endsequence
   sequence s_tr_done;
      busy [*2] ##1 (ram_write && !busy);
   endsequence
   property p_jump;
      quiet && jump_instruction && !call_instruction |=> program_counter == $past(operand_addr);
   endproperty
   property p_int;
      !busy && int_take && |int_pending |=> int_ack == $past(int_pending & (~int_pending + 5'h01));
   endproperty
   property p_vec;
      int_ack != 5'h00 |-> program_counter == {5'h00, int_ack[4], int_ack[3], int_ack[1] | int_ack[2],
         int_ack[0] | int_ack[2] | int_ack[3], 2'b00};
   endproperty
   property p_step;
      quiet && step && !jump_instruction && !call_instruction && !return_instruction && !table_read_instruction
         |=> program_counter == $past(program_counter) + 11'h001;
   endproperty
   property p_rst;
      disable iff (1'b0) reset |=> program_counter == 11'h000 && stack_level == 4'h0;
   endproperty
   property p_tab;
      s_tr |=> s_tr_done;
   endproperty
   property p_hot;
      $onehot0(int_ack);
   endproperty
   property p_lvl;
      stack_level <= 4'h8;
   endproperty
   property p_tab_addr;
      s_tr ##3 ram_write |-> ram_write_addr == $past(ram_dest_addr, 3);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   a_int: assert property (p_int) else $error("grant not highest");
   a_vec: assert property (p_vec) else $error("vector wrong");
   a_hot: assert property (p_hot) else $error("grant not one-hot");
   a_step: assert property (p_step) else $error("step wrong");
   a_lvl: assert property (p_lvl) else $error("stack too deep");
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_tab: assert property (p_tab) else $error("table read timing");
   a_tab_addr: assert property (p_tab_addr) else $error("table dest wrong");
endmodule : psq_props
bind psq_sequencer psq_props u_props (
   .clk_sys(clk_sys),
   .reset(reset),
   .step(step),
   .jump_instruction(jump_instruction),
   .call_instruction(call_instruction),
   .return_instruction(return_instruction),
   .operand_addr(operand_addr),
   .int_take(int_take),
   .int_pending(int_pending),
   .table_read_instruction(table_read_instruction),
   .ram_dest_addr(ram_dest_addr),
   .program_counter(program_counter),
   .int_ack(int_ack),
   .busy(busy),
   .ram_write(ram_write),
   .ram_write_addr(ram_write_addr),
   .stack_level(stack_level)
);

/* psq_sequencer_tb.sv */
module psq_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, reset = 1'b1, step = 1'b0, jump_instruction = 1'b0, call_instruction = 1'b0;
   logic return_instruction = 1'b0, int_take = 1'b0, load_table_high = 1'b0, load_table_low = 1'b0;
   logic table_read_instruction = 1'b0, busy, ram_write;
   logic [10:0] operand_addr = 11'h000, program_counter, rom_addr;
   logic [4:0] int_pending = 5'h00, int_ack;
   logic [3:0] ram_read_data = 4'h0, work_nibble_reg = 4'h0, ram_write_data, stack_level;
   logic [6:0] ram_dest_addr = 7'h00, ram_write_addr;
   logic [15:0] rom_data, w;
   logic [11:0] e;
   int num_errors = 0, num_checks = 0;
   psq_sequencer dut (
      .clk_sys(clk_sys),
      .reset(reset),
      .step(step),
      .jump_instruction(jump_instruction),
      .call_instruction(call_instruction),
      .return_instruction(return_instruction),
      .operand_addr(operand_addr),
      .int_take(int_take),
      .int_pending(int_pending),
      .load_table_high(load_table_high),
      .load_table_low(load_table_low),
      .ram_read_data(ram_read_data),
      .table_read_instruction(table_read_instruction),
      .work_nibble_reg(work_nibble_reg),
      .ram_dest_addr(ram_dest_addr),
      .rom_data(rom_data),
      .program_counter(program_counter),
      .rom_addr(rom_addr),
      .int_ack(int_ack),
      .busy(busy),
      .ram_write(ram_write),
      .ram_write_addr(ram_write_addr),
      .ram_write_data(ram_write_data),
      .stack_level(stack_level)
   );
   psq_rom_model rom (
      .clk_sys(clk_sys),
      .rom_addr(rom_addr),
      .rom_data(rom_data)
   );
   initial forever #2 clk_sys = ~clk_sys;
   task tick; @(negedge clk_sys); endtask : tick
   task automatic pulse(ref logic s); s = 1'b1; tick; s = 1'b0; tick; endtask : pulse
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task t_jump;
      operand_addr = 11'h7ff;
      pulse(jump_instruction);
      chk(rom_addr, 11'h7ff);
      chk(program_counter, 11'h7ff);
      pulse(step);
      chk(program_counter, 11'h000);
   endtask : t_jump
   task t_stack;
      operand_addr = 11'h100;
      pulse(jump_instruction);
      for (int i = 0; i < 9; i++) begin
         operand_addr = 11'(11'h200 + i);
         pulse(call_instruction);
      end
      chk(stack_level, 4'h8);
      // oldest return address 101 is gone
      for (int k = 8; k > 0; k--) begin
         pulse(return_instruction);
         chk(program_counter, 16'(11'h200 + k));
      end
      chk(stack_level, 4'h0);
   endtask : t_stack
   task automatic t_int;
      logic [10:0] vec [5] = '{11'h004, 11'h008, 11'h00c, 11'h014, 11'h020};
      for (int i = 0; i < 5; i++) begin
         operand_addr = 11'h300;
         pulse(jump_instruction);
         int_pending = 5'h1f << i;
         int_take = 1'b1;
         tick;
         int_take = 1'b0;
         chk(int_ack, 5'h01 << i);
         chk(program_counter, vec[i]);
         int_pending = 5'h00;
         tick;
         pulse(return_instruction);
         chk(program_counter, 11'h300);
      end
   endtask : t_int
   task automatic t_table;
      logic [11:0] cs [2] = '{12'hfff, 12'h5a6};
      for (int k = 0; k < 2; k++) begin
         e = cs[k];
         w = 16'h0600 + e[10:2];
         ram_read_data = e[11:8];
         pulse(load_table_high);
         ram_read_data = e[7:4];
         pulse(load_table_low);
         work_nibble_reg = e[3:0];
         ram_dest_addr = 7'(7'h7f - k);
         table_read_instruction = 1'b1;
         tick;
         table_read_instruction = 1'b0;
         chk(rom_addr, w);
         chk(busy, 1'b1);
         tick;
         tick;
         w = {~w[4:0], w[10:0]} >> (4 * e[1:0]);
         chk(ram_write, 1'b1);
         chk(ram_write_data, w[3:0]);
         chk(ram_write_addr, 16'(7'h7f - k));
         tick;
      end
   endtask : t_table
   // call beats a jump in the same cycle, then a mid-run reset empties the stack
   task t_reset;
      operand_addr = 11'h155;
      jump_instruction = 1'b1;
      pulse(call_instruction);
      jump_instruction = 1'b0;
      chk(stack_level, 4'h1);
      chk(program_counter, 11'h155);
      reset = 1'b1;
      tick;
      reset = 1'b0;
      tick;
      chk(program_counter, 11'h000);
      chk(stack_level, 4'h0);
   endtask : t_reset
   task tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      #20000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (12) tick;
      reset = 1'b0;
      tick;
      chk(program_counter, 11'h000);
      t_jump;
      t_stack;
      t_int;
      t_reset;
      t_table;
      tally_and_finish;
   end
endmodule : psq_sequencer_tb
